// *** src/branch_skip_compare_unit.sv ***
// branch, skip and compare execution unit with an AXI4-Lite register file
// assumes software loads operands, flags and pc, then writes the start bit
//
// Operation
// [RULE1] equal registers skip next instruction, flags kept
// [RULE2] compares update five flags in one cycle
// [RULE3] register bit clear skips next instruction
// [RULE4] register bit set skips next instruction
// [RULE5] io bit clear skips next instruction
// [RULE6] io bit set skips next instruction
// [RULE7] selected flag set branches to pc+k+1
// [RULE8] selected flag clear branches to pc+k+1
// [RULE9] zero flag selects equal or not equal
// [RULE10] carry flag selects carry set or clear
// [RULE11] same-higher and lower mirror carry branches
// [RULE12] negative flag selects minus or plus
// [RULE13] n xor v zero takes greater-equal
// [RULE14] n xor v one takes less-than
// [RULE15] half carry flag branches set or clear
// [RULE16] transfer bit branches set or clear
// [RULE17] overflow flag branches set or clear
// [RULE18] interrupt enable flag branches set or clear
// [RULE19] skip costs one extra cycle per word
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module branch_skip_compare_unit #(
	parameter int unsigned ADDR_W = branch_skip_pkg::ADDR_W
) (
	// clock and reset
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	// write address channel
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	// write data channel
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	// write response channel
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	output logic [1:0]             S_AXI_BRESP,
	// read address channel
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	// read data channel
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	// core status
	output logic                   BUSY
);
	localparam int unsigned IDX_W = ADDR_W - 2;

	typedef enum logic [1:0] {idle_st, exec_st, hold_st} state_e;

	state_e                       st_reg;
	logic [1:0]                   cnt_reg;
	branch_skip_pkg::op_s         op_reg;
	branch_skip_pkg::opnd_s       opnd_reg;
	logic [15:0]                  pc_reg;
	logic [7:0]                   flags_reg;
	logic                         two_word_reg;
	logic                         taken_reg;
	logic [1:0]                   last_cyc_reg;
	logic                         aw_full_reg;
	logic [ADDR_W-1:0]            aw_addr_reg;
	logic                         w_full_reg;
	logic [31:0]                  w_data_reg;
	logic [3:0]                   w_strb_reg;
	logic                         b_valid_reg;
	logic [1:0]                   b_resp_reg;
	logic                         r_valid_reg;
	logic [31:0]                  r_data_reg;
	logic [1:0]                   r_resp_reg;
	logic [31:0]                  view [2**IDX_W];
	logic [IDX_W-1:0]             w_idx;
	logic [IDX_W-1:0]             r_idx;
	logic [31:0]                  wr_word;
	logic                         wr_fire;
	logic                         wr_idle;
	logic                         start;
	branch_skip_pkg::cmp_flags_s  cmp_flags;
	logic                         taken_next;
	logic [1:0]                   cyc_next;
	logic [15:0]                  pc_next;
	logic [7:0]                   flags_next;
	logic [15:0]                  k_ext;
	logic                         exec;

	// byte-lane merge of a bus write into the current register word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = data[8*i +: 8];
			end
		end
		return res;
	endfunction

	// register index of a byte offset
	function automatic logic hit(input logic [IDX_W-1:0] idx, input int unsigned off);
		return idx == IDX_W'(off >> 2);
	endfunction

	function automatic logic is_branch(input branch_skip_pkg::op_e op);
		return op >= branch_skip_pkg::branch_flag_set && op <= branch_skip_pkg::branch_irq_disabled;
	endfunction

	function automatic logic is_compare(input branch_skip_pkg::op_e op);
		return op inside {branch_skip_pkg::compare_regs, branch_skip_pkg::compare_regs_with_carry,
			branch_skip_pkg::compare_immediate};
	endfunction

	// branch condition from the flags, per operation
	function automatic logic branch_cond(input branch_skip_pkg::op_e op, input logic [2:0] sel,
			input logic [7:0] f);
		logic nv;
		nv = f[branch_skip_pkg::FLAG_N] ^ f[branch_skip_pkg::FLAG_V];
		case (op)
			// [RULE7] selected flag set
			branch_skip_pkg::branch_flag_set:         return f[sel];
			// [RULE8] selected flag clear
			branch_skip_pkg::branch_flag_clear:       return !f[sel];
			// [RULE9] zero flag test
			branch_skip_pkg::branch_equal:            return f[branch_skip_pkg::FLAG_Z];
			branch_skip_pkg::branch_not_equal:        return !f[branch_skip_pkg::FLAG_Z];
			// [RULE10] carry flag test
			branch_skip_pkg::branch_carry_set:        return f[branch_skip_pkg::FLAG_C];
			branch_skip_pkg::branch_carry_clear:      return !f[branch_skip_pkg::FLAG_C];
			// [RULE11] unsigned carry aliases
			branch_skip_pkg::branch_same_higher:      return !f[branch_skip_pkg::FLAG_C];
			branch_skip_pkg::branch_lower:            return f[branch_skip_pkg::FLAG_C];
			// [RULE12] negative flag test
			branch_skip_pkg::branch_minus:            return f[branch_skip_pkg::FLAG_N];
			branch_skip_pkg::branch_plus:             return !f[branch_skip_pkg::FLAG_N];
			// [RULE13] signed greater-equal
			branch_skip_pkg::branch_ge_signed:        return !nv;
			// [RULE14] signed less-than
			branch_skip_pkg::branch_lt_signed:        return nv;
			// [RULE15] half carry test
			branch_skip_pkg::branch_half_carry_set:   return f[branch_skip_pkg::FLAG_H];
			branch_skip_pkg::branch_half_carry_clear: return !f[branch_skip_pkg::FLAG_H];
			// [RULE16] transfer bit test
			branch_skip_pkg::branch_tbit_set:         return f[branch_skip_pkg::FLAG_T];
			branch_skip_pkg::branch_tbit_clear:       return !f[branch_skip_pkg::FLAG_T];
			// [RULE17] overflow flag test
			branch_skip_pkg::branch_overflow_set:     return f[branch_skip_pkg::FLAG_V];
			branch_skip_pkg::branch_overflow_clear:   return !f[branch_skip_pkg::FLAG_V];
			// [RULE18] interrupt enable test
			branch_skip_pkg::branch_irq_enabled:      return f[branch_skip_pkg::FLAG_I];
			branch_skip_pkg::branch_irq_disabled:     return !f[branch_skip_pkg::FLAG_I];
			default:                                  return 1'h0;
		endcase
	endfunction

	// bus write path: address and data latch in either order
	assign S_AXI_AWREADY = !aw_full_reg && !b_valid_reg;
	assign S_AXI_WREADY  = !w_full_reg && !b_valid_reg;
	assign S_AXI_BVALID  = b_valid_reg;
	assign S_AXI_BRESP   = b_resp_reg;
	assign wr_fire       = aw_full_reg && w_full_reg && !b_valid_reg;
	assign w_idx         = aw_addr_reg[ADDR_W-1:2];
	assign wr_word       = merge(view[w_idx], w_data_reg, w_strb_reg);
	// writes while busy are dropped so a running operation sees stable inputs
	assign wr_idle       = wr_fire && st_reg == idle_st;
	assign start         = wr_idle && hit(w_idx, branch_skip_pkg::CTRL_OFF) && w_strb_reg[0]
		&& w_data_reg[branch_skip_pkg::CTRL_START_BIT];

	// write address holding register
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			aw_full_reg <= 1'h0;
			aw_addr_reg <= '0;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_full_reg <= 1'h1;
			aw_addr_reg <= S_AXI_AWADDR;
		end else if (wr_fire) begin
			aw_full_reg <= 1'h0;
		end
	end

	// write data holding register
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			w_full_reg <= 1'h0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_full_reg <= 1'h1;
			w_data_reg <= S_AXI_WDATA;
			w_strb_reg <= S_AXI_WSTRB;
		end else if (wr_fire) begin
			w_full_reg <= 1'h0;
		end
	end

	// write response, error for an unmapped word
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			b_valid_reg <= 1'h0;
			b_resp_reg  <= branch_skip_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			b_valid_reg <= 1'h1;
			b_resp_reg  <= (w_idx < IDX_W'(branch_skip_pkg::NUM_REGS)) ?
				branch_skip_pkg::RESP_OKAY : branch_skip_pkg::RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			b_valid_reg <= 1'h0;
		end
	end

	// register view for reads and byte merges
	always_comb begin
		for (int i = 0; i < 2**IDX_W; i++) begin
			view[i] = 32'h0000_0000;
		end
		view[branch_skip_pkg::OP_OFF >> 2]    = {17'h00000, op_reg};
		view[branch_skip_pkg::OPND_OFF >> 2]  = {8'h00, opnd_reg};
		view[branch_skip_pkg::PC_OFF >> 2]    = {16'h0000, pc_reg};
		view[branch_skip_pkg::FLAGS_OFF >> 2] = {24'h000000, flags_reg};
		view[branch_skip_pkg::FETCH_OFF >> 2] = {31'h00000000, two_word_reg};
		view[branch_skip_pkg::STAT_OFF >> 2]  = {26'h0000000, last_cyc_reg, 2'h0, taken_reg, BUSY};
	end

	// bus read path: one word per request, answered the next cycle
	assign S_AXI_ARREADY = !r_valid_reg;
	assign S_AXI_RVALID  = r_valid_reg;
	assign S_AXI_RDATA   = r_data_reg;
	assign S_AXI_RRESP   = r_resp_reg;
	assign r_idx         = S_AXI_ARADDR[ADDR_W-1:2];

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			r_valid_reg <= 1'h0;
			r_data_reg  <= 32'h0000_0000;
			r_resp_reg  <= branch_skip_pkg::RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			r_valid_reg <= 1'h1;
			r_data_reg  <= view[r_idx];
			r_resp_reg  <= (r_idx < IDX_W'(branch_skip_pkg::NUM_REGS)) ?
				branch_skip_pkg::RESP_OKAY : branch_skip_pkg::RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			r_valid_reg <= 1'h0;
		end
	end

	// operation inputs written by software while idle
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			op_reg       <= '0;
			opnd_reg     <= '0;
			two_word_reg <= 1'h0;
		end else if (wr_idle) begin
			if (hit(w_idx, branch_skip_pkg::OP_OFF)) begin
				op_reg <= branch_skip_pkg::op_s'(wr_word[14:0]);
			end
			if (hit(w_idx, branch_skip_pkg::OPND_OFF)) begin
				opnd_reg <= wr_word[23:0];
			end
			if (hit(w_idx, branch_skip_pkg::FETCH_OFF)) begin
				two_word_reg <= wr_word[branch_skip_pkg::FETCH_TWO_BIT];
			end
		end
	end

	// compare flag generator
	compare_sub u_cmp (
		.A          (opnd_reg.dst),
		.B          (opnd_reg.src),
		.CARRY_IN   (flags_reg[branch_skip_pkg::FLAG_C]),
		.WITH_CARRY (op_reg.op == branch_skip_pkg::compare_regs_with_carry),
		.ZERO_IN    (flags_reg[branch_skip_pkg::FLAG_Z]),
		.FLAGS      (cmp_flags)
	);

	assign k_ext = {{9{op_reg.offset[6]}}, op_reg.offset};
	assign exec  = st_reg == exec_st;
	assign BUSY  = st_reg != idle_st;

	// outcome of the loaded operation: next pc, flags, cycle count
	always_comb begin
		taken_next = 1'h0;
		flags_next = flags_reg;
		case (op_reg.op)
			// [RULE1] equal registers skip
			branch_skip_pkg::compare_skip_equal: taken_next = opnd_reg.dst == opnd_reg.src;
			// [RULE3] register bit clear
			branch_skip_pkg::skip_reg_bit_clear: taken_next = !opnd_reg.src[op_reg.sel];
			// [RULE4] register bit set
			branch_skip_pkg::skip_reg_bit_set:   taken_next = opnd_reg.src[op_reg.sel];
			// [RULE5] io bit clear
			branch_skip_pkg::skip_io_bit_clear:  taken_next = !opnd_reg.io_val[op_reg.sel];
			// [RULE6] io bit set
			branch_skip_pkg::skip_io_bit_set:    taken_next = opnd_reg.io_val[op_reg.sel];
			default:                             taken_next = branch_cond(op_reg.op, op_reg.sel,
				flags_reg);
		endcase
		// [RULE2] compare flag update
		if (is_compare(op_reg.op)) begin
			flags_next[branch_skip_pkg::FLAG_H] = cmp_flags.h;
			flags_next[branch_skip_pkg::FLAG_V] = cmp_flags.v;
			flags_next[branch_skip_pkg::FLAG_N] = cmp_flags.n;
			flags_next[branch_skip_pkg::FLAG_Z] = cmp_flags.z;
			flags_next[branch_skip_pkg::FLAG_C] = cmp_flags.c;
		end
		cyc_next = branch_skip_pkg::CYC_ONE;
		pc_next  = pc_reg + branch_skip_pkg::STEP_ONE;
		if (taken_next && is_branch(op_reg.op)) begin
			cyc_next = branch_skip_pkg::CYC_TWO;
			pc_next  = pc_reg + branch_skip_pkg::STEP_ONE + k_ext;
		end else if (taken_next) begin
			// [RULE19] two-word skip cost
			cyc_next = two_word_reg ? branch_skip_pkg::CYC_THREE : branch_skip_pkg::CYC_TWO;
			pc_next  = pc_reg + (two_word_reg ? branch_skip_pkg::STEP_THR :
				branch_skip_pkg::STEP_TWO);
		end
	end

	// sequencer: one execute cycle, then the extra cycles of a taken path
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_reg <= idle_st;
		end else begin
			case (st_reg)
				idle_st: begin
					if (start) begin
						st_reg <= exec_st;
					end
				end
				exec_st: begin
					st_reg <= (cyc_next > branch_skip_pkg::CYC_ONE) ? hold_st : idle_st;
				end
				hold_st: begin
					if (cnt_reg == 2'h1) begin
						st_reg <= idle_st;
					end
				end
				default: st_reg <= idle_st;
			endcase
		end
	end

	// remaining extra cycles
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cnt_reg <= 2'h0;
		end else if (exec) begin
			cnt_reg <= cyc_next - branch_skip_pkg::CYC_ONE;
		end else if (st_reg == hold_st) begin
			cnt_reg <= cnt_reg - 2'h1;
		end
	end

	// program counter: software load while idle, result at execute
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pc_reg <= branch_skip_pkg::PC_RST;
		end else if (exec) begin
			pc_reg <= pc_next;
		end else if (wr_idle && hit(w_idx, branch_skip_pkg::PC_OFF)) begin
			pc_reg <= wr_word[15:0];
		end
	end

	// status flags: only compares change them during execute
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			flags_reg <= branch_skip_pkg::FLAGS_RST;
		end else if (exec) begin
			flags_reg <= flags_next;
		end else if (wr_idle && hit(w_idx, branch_skip_pkg::FLAGS_OFF)) begin
			flags_reg <= wr_word[7:0];
		end
	end

	// outcome of the last operation for software
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			taken_reg    <= 1'h0;
			last_cyc_reg <= 2'h0;
		end else if (exec) begin
			taken_reg    <= taken_next;
			last_cyc_reg <= cyc_next;
		end
	end

	// checks on the execute outcome
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	skip_equal_a: assert property ( // [RULE1]
		exec && op_reg.op == branch_skip_pkg::compare_skip_equal && opnd_reg.dst == opnd_reg.src
		&& !two_word_reg |=> pc_reg == $past(pc_reg) + branch_skip_pkg::STEP_TWO
		&& flags_reg == $past(flags_reg) ##1 st_reg == idle_st)
		else $error("equal compare did not skip one word");
	compare_one_a: assert property ( // [RULE2]
		exec && is_compare(op_reg.op) |=> st_reg == idle_st
		&& flags_reg[branch_skip_pkg::FLAG_C] == $past(cmp_flags.c)
		&& flags_reg[branch_skip_pkg::FLAG_Z] == $past(cmp_flags.z)
		&& pc_reg == $past(pc_reg) + branch_skip_pkg::STEP_ONE)
		else $error("compare did not finish in one cycle with new flags");
	skip_two_words_a: assert property ( // [RULE3] [RULE19]
		exec && op_reg.op == branch_skip_pkg::skip_reg_bit_clear && !opnd_reg.src[op_reg.sel]
		&& two_word_reg |=> (st_reg == hold_st
		&& pc_reg == $past(pc_reg) + branch_skip_pkg::STEP_THR)
		##1 st_reg == hold_st ##1 st_reg == idle_st)
		else $error("skip over two words wrong pc or length");
	skip_not_taken_a: assert property ( // [RULE4]
		exec && op_reg.op == branch_skip_pkg::skip_reg_bit_set && !opnd_reg.src[op_reg.sel]
		|=> st_reg == idle_st && pc_reg == $past(pc_reg) + branch_skip_pkg::STEP_ONE)
		else $error("skip taken on a clear bit");
	io_skip_flags_a: assert property ( // [RULE5] [RULE6]
		exec && op_reg.op inside {branch_skip_pkg::skip_io_bit_clear,
		branch_skip_pkg::skip_io_bit_set} |=> flags_reg == $past(flags_reg)
		&& taken_reg == ($past(opnd_reg.io_val[op_reg.sel]) ==
		($past(op_reg.op) == branch_skip_pkg::skip_io_bit_set)))
		else $error("io bit skip wrong decision or flags changed");
	branch_taken_a: assert property ( // [RULE7] [RULE8] [RULE15] [RULE16] [RULE17] [RULE18]
		exec && is_branch(op_reg.op) && taken_next |=> (st_reg == hold_st
		&& pc_reg == $past(pc_reg) + branch_skip_pkg::STEP_ONE + $past(k_ext))
		##1 st_reg == idle_st)
		else $error("taken branch wrong target or length");
	branch_flags_a: assert property ( // [RULE9] [RULE12]
		exec && is_branch(op_reg.op) |=> flags_reg == $past(flags_reg))
		else $error("branch changed the status flags");
	branch_equal_a: assert property ( // [RULE9]
		exec && op_reg.op == branch_skip_pkg::branch_equal && !flags_reg[branch_skip_pkg::FLAG_Z]
		|=> pc_reg == $past(pc_reg) + branch_skip_pkg::STEP_ONE && st_reg == idle_st)
		else $error("equal branch taken with zero clear");
	carry_alias_a: assert property ( // [RULE10] [RULE11]
		exec && op_reg.op inside {branch_skip_pkg::branch_same_higher,
		branch_skip_pkg::branch_carry_clear} |-> taken_next == !flags_reg[branch_skip_pkg::FLAG_C])
		else $error("same-higher does not follow clear carry");
	signed_branch_a: assert property ( // [RULE13] [RULE14]
		exec && op_reg.op inside {branch_skip_pkg::branch_ge_signed,
		branch_skip_pkg::branch_lt_signed} |-> taken_next == ((flags_reg[branch_skip_pkg::FLAG_N]
		^ flags_reg[branch_skip_pkg::FLAG_V]) == (op_reg.op == branch_skip_pkg::branch_lt_signed)))
		else $error("signed branch ignores n xor v");

	skip_two_c: cover property (exec && taken_next && !is_branch(op_reg.op) && two_word_reg);
	branch_c: cover property (exec && is_branch(op_reg.op) && taken_next);
	compare_c: cover property (exec && op_reg.op == branch_skip_pkg::compare_regs_with_carry);
endmodule
`default_nettype wire

// *** src/branch_skip_pkg.sv ***
// constants, modes and carriers for the branch, skip and compare unit
// assumes a 32-bit AXI4-Lite register bus and one core clock
`default_nettype none
package branch_skip_pkg;
	// register byte offsets
	localparam int unsigned ADDR_W    = 5;
	localparam int unsigned CTRL_OFF  = 'h00;
	localparam int unsigned OP_OFF    = 'h04;
	localparam int unsigned OPND_OFF  = 'h08;
	localparam int unsigned PC_OFF    = 'h0c;
	localparam int unsigned FLAGS_OFF = 'h10;
	localparam int unsigned FETCH_OFF = 'h14;
	localparam int unsigned STAT_OFF  = 'h18;
	localparam int unsigned NUM_REGS  = 7;
	// field positions
	localparam int unsigned CTRL_START_BIT = 0;
	localparam int unsigned FETCH_TWO_BIT  = 0;
	// status flag positions
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_T = 6;
	localparam int unsigned FLAG_I = 7;
	// reset values
	localparam logic [15:0] PC_RST   = 16'h0000;
	localparam logic [7:0]  FLAGS_RST = 8'h00;
	// cycle counts and program counter steps
	localparam logic [1:0]  CYC_ONE   = 2'h1;
	localparam logic [1:0]  CYC_TWO   = 2'h2;
	localparam logic [1:0]  CYC_THREE = 2'h3;
	localparam logic [15:0] STEP_ONE  = 16'h0001;
	localparam logic [15:0] STEP_TWO  = 16'h0002;
	localparam logic [15:0] STEP_THR  = 16'h0003;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		compare_skip_equal, compare_regs, compare_regs_with_carry, compare_immediate,
		skip_reg_bit_clear, skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set,
		branch_flag_set, branch_flag_clear, branch_equal, branch_not_equal,
		branch_carry_set, branch_carry_clear, branch_same_higher, branch_lower,
		branch_minus, branch_plus, branch_ge_signed, branch_lt_signed,
		branch_half_carry_set, branch_half_carry_clear, branch_tbit_set,
		branch_tbit_clear, branch_overflow_set, branch_overflow_clear,
		branch_irq_enabled, branch_irq_disabled
	} op_e;

	// instruction word: offset k, bit select, operation
	typedef struct packed {
		logic [6:0] offset;
		logic [2:0] sel;
		op_e        op;
	} op_s;

	// operand word: io value, source or immediate, destination
	typedef struct packed {
		logic [7:0] io_val;
		logic [7:0] src;
		logic [7:0] dst;
	} opnd_s;

	// flags produced by a compare
	typedef struct packed {
		logic h;
		logic v;
		logic n;
		logic z;
		logic c;
	} cmp_flags_s;
endpackage
`default_nettype wire

// *** src/compare_sub.sv ***
// subtract-and-discard flag generator for the compare operations
// assumes operands are stable for the whole execute cycle
`timescale 1ns/1ns
`default_nettype none
module compare_sub (
	// operands
	input  wire logic [7:0]                  A,
	input  wire logic [7:0]                  B,
	// carry chain
	input  wire logic                        CARRY_IN,
	input  wire logic                        WITH_CARRY,
	input  wire logic                        ZERO_IN,
	// result flags
	output var branch_skip_pkg::cmp_flags_s  FLAGS
);
	logic [7:0] diff;
	logic       cin;
	logic       half;
	logic       borrow;
	logic       ovf;
	logic       zero;

	// the difference itself is never written back
	assign cin  = WITH_CARRY & CARRY_IN;
	assign diff = A - B - {7'h00, cin};

	// borrow out of bit 3 and bit 7, signed overflow
	assign half   = (~A[3] & B[3]) | (B[3] & diff[3]) | (diff[3] & ~A[3]);
	assign borrow = (~A[7] & B[7]) | (B[7] & diff[7]) | (diff[7] & ~A[7]);
	assign ovf    = (A[7] & ~B[7] & ~diff[7]) | (~A[7] & B[7] & diff[7]);
	// with carry the zero flag chains, so multi-byte compares work
	assign zero   = (diff == 8'h00) & (~WITH_CARRY | ZERO_IN);
	// one driver for the whole carrier
	assign FLAGS  = '{h: half, v: ovf, n: diff[7], z: zero, c: borrow};
endmodule
`default_nettype wire

// *** dv/tb_branch_skip_compare_unit.sv ***
// self-checking bench for the branch, skip and compare unit
// assumes the unit's register map, one core clock and an axi4-lite slave
`timescale 1ns/1ns
`default_nettype none
module tb_branch_skip_compare_unit;
	// bus and core signals
	logic        clk = 0, rst = 1, awv = 0, wv = 0, arv = 0;
	logic [4:0]  awa = 0, ara = 0;
	logic [31:0] wd = 0, rdat;
	logic [1:0]  bresp, rresp;
	logic        awr, wrdy, bv, arr, rv, busy;
	logic [33:0] rq[$], e;
	logic [1:0]  bq[$];
	int          err_total = 0, n_compared = 0, cyc = 0;
	always #10 clk = ~clk;
	branch_skip_compare_unit uut (.CLK(clk), .SYS_RST(rst), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1),
		.S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
		.BUSY(busy));
	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// answers arrive in order, so the oldest note always matches; also the hang guard
	always @(posedge clk) begin
		if (rv === 1'b1) begin
			e = rq.pop_front();
			n_compared++;
			if ({rresp, rdat} !== e) begin
				err_total++;
				$display("unexpected at %0t: read %h want %h", $time, {rresp, rdat}, e);
			end
		end
		if (bv === 1'b1) begin
			e[1:0] = bq.pop_front();
			n_compared++;
			if (bresp !== e[1:0]) begin
				err_total++;
				$display("unexpected at %0t: write answer %h", $time, bresp);
			end
		end
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			summarize();
		end
	end
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back(r);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		do begin
			@(posedge clk);
			if (awr === 1'b1) awv <= 0;
			if (wrdy === 1'b1) wv <= 0;
		end while (awv || wv);
		do @(posedge clk); while (bv !== 1'b1);
	endtask
	task automatic rd(input logic [4:0] a, input logic [33:0] x);
		rq.push_back(x);
		ara <= a;
		arv <= 1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 0;
		do @(posedge clk); while (rv !== 1'b1);
	endtask
	// loads one random operation, starts it and checks pc, flags and cycle count
	task automatic run(input logic [4:0] op);
		logic [7:0]  f, d, r, p, nf;
		logic [2:0]  s;
		logic [6:0]  k;
		logic        two, t, cin;
		logic [8:0]  df;
		logic [4:0]  hd;
		logic [15:0] pc, px;
		logic [1:0]  c;
		int          i, bc;
		f = 8'($urandom);
		d = 8'($urandom);
		r = ($urandom % 2) ? d : 8'($urandom);
		p = 8'($urandom);
		s = 3'($urandom);
		k = 7'($urandom);
		pc = 16'($urandom);
		two = 1'($urandom);
		i = op < 12 ? 1 : op < 16 ? 0 : op < 18 ? 2 : op < 22 ? 5 : op < 24 ? 6 : op < 26 ? 3 : 7;
		case (op)
			0: t = (d == r);
			1, 2, 3: t = 0;
			4, 5: t = r[s] ^ !op[0];
			6, 7: t = p[s] ^ !op[0];
			8, 9: t = f[s] ^ op[0];
			18, 19: t = f[2] ^ f[3] ^ !op[0];
			28, 29, 30, 31: t = 0; // unassigned codes never branch
			default: t = f[i] ^ op[0] ^ (op == 14 || op == 15);
		endcase
		cin = (op == 2) & f[0];
		df = {1'b0, d} - {1'b0, r} - {8'h00, cin};
		hd = {1'b0, d[3:0]} - {1'b0, r[3:0]} - {4'h0, cin};
		nf = f;
		if (op inside {[1:3]}) nf = {f[7:6], hd[4], f[4], (d[7] ^ r[7]) & (d[7] ^ df[7]),
			df[7], (df[7:0] == 0) & (op != 2 || f[1]), df[8]};
		c = !t ? 2'h1 : (op < 8 && two) ? 2'h3 : 2'h2;
		px = !t ? pc + 16'h1 : op < 8 ? pc + c : pc + {{9{k[6]}}, k} + 16'h1;
		wr(5'h04, {17'h0, k, s, op}, 2'h0);
		wr(5'h08, {8'h0, p, r, d}, 2'h0);
		wr(5'h0c, {16'h0, pc}, 2'h0);
		wr(5'h10, {24'h0, f}, 2'h0);
		wr(5'h14, {31'h0, two}, 2'h0);
		wr(5'h00, 32'h1, 2'h0);
		// busy stands one cycle for each cycle the operation costs
		bc = 0;
		while (busy !== 1'h0) begin
			bc++;
			@(posedge clk);
		end
		n_compared++;
		if (bc != int'(c)) begin
			err_total++;
			$display("unexpected at %0t: busy %0d cycles want %0d", $time, bc, c);
		end
		rd(5'h0c, {18'h0, px});
		rd(5'h10, {26'h0, nf});
		rd(5'h18, {28'h0, c, 2'h0, t, 1'b0});
	endtask
	initial begin
		void'($urandom(29380));
		repeat (8) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(5'h0c, 34'h0);
		rd(5'h10, 34'h0);
		// unmapped place answers with an error, status place ignores writes
		wr(5'h1c, 32'h5, 2'h2);
		rd(5'h1c, {2'h2, 32'h0});
		wr(5'h18, 32'hff, 2'h0);
		rd(5'h18, 34'h0);
		for (int n = 0; n < 48; n++) run(5'(n % 8));
		for (int n = 0; n < 60; n++) run(5'(8 + n % 10));
		for (int n = 0; n < 60; n++) run(5'(18 + n % 10));
		for (int n = 0; n < 8; n++) run(5'(28 + n % 4));
		summarize();
	end
endmodule
`default_nettype wire
